// *** logic/spb_pkg.sv ***
package spb_pkg;
	// ------------------------------------------------------------
	// Packet format
	// ------------------------------------------------------------
	localparam logic [7:0] burst_pulsed_output_opcode = 8'h0d;
	localparam logic [7:0] burst_pulsed_input_opcode = 8'h0e;
	localparam int SPB_PKT_LEN = 8;
	localparam logic [2:0] SPB_LAST_POS = 3'h7;
	localparam logic [2:0] SPB_OPC_POS = 3'h0;
	localparam logic [2:0] SPB_CNT_POS = 3'h1;
	localparam logic [2:0] SPB_DATA_POS = 3'h2;
	localparam logic [7:0] SPB_MIN_BYTES = 8'h01;
	localparam logic [7:0] SPB_MAX_BYTES = 8'h06;
	// Strobe selector: line in [3:0], bit 4 positive pulse; bit 8 of the SEL register picks port B
	localparam int SPB_SEL_POL_BIT = 4;
	localparam int SPB_SEL_W = 5;
	localparam int SPB_LINE_W = 4;
	localparam int SPB_LINES = 16;
	localparam int SPB_PORT_W = 8;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] SPB_ADDR_SEL = 8'h00;
	localparam logic [7:0] SPB_ADDR_LEN = 8'h04;
	localparam logic [7:0] SPB_ADDR_DEL = 8'h08;
	localparam logic [7:0] SPB_ADDR_STATUS = 8'h0c;
	localparam int SPB_PORT_BIT = 8;
	localparam logic [5:0] SPB_SEL_RESET = 6'h0f;
	localparam logic [7:0] SPB_LEN_RESET = 8'h00;
	localparam logic [7:0] SPB_DEL_RESET = 8'h00;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int SPB_CLK_NS = 10;
	localparam int SPB_STROBE_BASE_NS = 10000;
	localparam int SPB_STROBE_STEP_NS = 750;
	localparam int SPB_GAP_STEP_NS = 1000;
	localparam int SPB_SETUP_NS = 20;
	localparam int SPB_HOLD_NS = 10;
	// Least times round up
	localparam int SPB_STROBE_BASE_CYC = (SPB_STROBE_BASE_NS + SPB_CLK_NS - 1) / SPB_CLK_NS;
	localparam int SPB_STROBE_STEP_CYC = (SPB_STROBE_STEP_NS + SPB_CLK_NS - 1) / SPB_CLK_NS;
	localparam int SPB_GAP_STEP_CYC = (SPB_GAP_STEP_NS + SPB_CLK_NS - 1) / SPB_CLK_NS;
	localparam logic [15:0] SPB_SETUP_CYC = 16'((SPB_SETUP_NS + SPB_CLK_NS - 1) / SPB_CLK_NS);
	localparam logic [15:0] SPB_HOLD_CYC = 16'((SPB_HOLD_NS + SPB_CLK_NS - 1) / SPB_CLK_NS);
	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE = 6'b00_0001,
		ST_SETUP = 6'b00_0010,
		ST_STROBE = 6'b00_0100,
		ST_HOLD = 6'b00_1000,
		ST_GAP = 6'b01_0000,
		ST_REPLY = 6'b10_0000
	} spb_state_type;
endpackage : spb_pkg

// *** logic/spb_sync.sv ***
`timescale 1ns/1ps
module spb_sync
	import spb_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// A bit only changes once the last two stages agree, so one metastable
	// sample can never produce a glitch downstream.
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					stage1[g] <= 1'b0;
					stage2[g] <= 1'b0;
					stage3[g] <= 1'b0;
					sync_o[g] <= 1'b0;
				end else begin
					stage1[g] <= async_i[g];
					stage2[g] <= stage1[g];
					stage3[g] <= stage2[g];
					if (stage2[g] == stage3[g]) begin
						sync_o[g] <= stage3[g];
					end
				end
			end
		end
	endgenerate
endmodule : spb_sync

// *** logic/spb_fifo.sv ***
`timescale 1ns/1ps
module spb_fifo
	import spb_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;

	assign in_ready_o = (count != (PW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];

	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule : spb_fifo

// *** logic/spb_burst.sv ***
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
module spb_burst
	import spb_pkg::*;
#(
	parameter int STROBE_BASE_CYC = SPB_STROBE_BASE_CYC,
	parameter int STROBE_STEP_CYC = SPB_STROBE_STEP_CYC,
	parameter int GAP_STEP_CYC = SPB_GAP_STEP_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Request packet, one byte per handshake
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic [7:0] cmd_data_i,
	// Reply packet, one byte per handshake
	output logic rsp_valid_o,
	input wire logic rsp_ready_i,
	output logic [7:0] rsp_data_o,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Pin levels and directions set by the rest of the device
	input wire logic [SPB_LINES-1:0] base_out_i,
	input wire logic [SPB_LINES-1:0] base_oe_n_i,
	// Port pins: A in [7:0], B in [15:8]
	input wire logic [SPB_LINES-1:0] pin_in_i,
	output logic [SPB_LINES-1:0] pin_out_o,
	output logic [SPB_LINES-1:0] pin_oe_n_o,
	output logic busy_o
);
	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic [SPB_SEL_W-1:0] cfg_sel;
	logic cfg_port;
	logic [7:0] cfg_len;
	logic [7:0] cfg_del;

	wire hit_sel = (reg_addr_i == SPB_ADDR_SEL);
	wire hit_len = (reg_addr_i == SPB_ADDR_LEN);
	wire hit_del = (reg_addr_i == SPB_ADDR_DEL);
	wire hit_status = (reg_addr_i == SPB_ADDR_STATUS);

	spb_state_type state;
	spb_state_type next_state;
	logic [2:0] byte_idx;
	logic [2:0] last_idx;
	logic [2:0] pkt_idx;

	wire [31:0] sel_word = {23'h00_0000, cfg_port, 3'h0, cfg_sel};
	wire [31:0] status_word = {28'h000_0000, byte_idx, busy_o};
	wire [31:0] read_word = hit_sel ? sel_word :
		hit_len ? {24'h00_0000, cfg_len} :
		hit_del ? {24'h00_0000, cfg_del} :
		hit_status ? status_word : 32'h0000_0000;

	// Register writes set these; bursts reuse them.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_sel <= SPB_SEL_RESET[SPB_SEL_W-1:0];
			cfg_port <= SPB_SEL_RESET[SPB_SEL_W];
			cfg_len <= SPB_LEN_RESET;
			cfg_del <= SPB_DEL_RESET;
			reg_rdata_o <= 32'h0000_0000;
		end else begin
			if (reg_wr_i && hit_sel) begin
				cfg_sel <= reg_wdata_i[SPB_SEL_W-1:0];
				cfg_port <= reg_wdata_i[SPB_PORT_BIT];
			end
			if (reg_wr_i && hit_len) begin
				cfg_len <= reg_wdata_i[7:0];
			end
			if (reg_wr_i && hit_del) begin
				cfg_del <= reg_wdata_i[7:0];
			end
			reg_rdata_o <= reg_rd_i ? read_word : 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// Request capture and decode
	// ------------------------------------------------------------
	logic [7:0] cmd_mem [0:SPB_PKT_LEN-1];
	logic [7:0] rsp_mem [0:SPB_PKT_LEN-1];
	logic act_write;
	logic act_port;
	logic [SPB_LINE_W-1:0] act_line;
	logic act_pos;
	logic [7:0] act_len;
	logic [7:0] act_del;
	logic [15:0] timer;
	logic [15:0] next_timer;

	wire cmd_take = cmd_valid_i && cmd_ready_o;
	wire pkt_done = cmd_take && (pkt_idx == SPB_LAST_POS);
	wire [7:0] opcode = cmd_mem[SPB_OPC_POS];
	wire [7:0] count = cmd_mem[SPB_CNT_POS];
	wire is_out = (opcode == burst_pulsed_output_opcode);
	wire is_in = (opcode == burst_pulsed_input_opcode);
	wire count_ok = (count >= SPB_MIN_BYTES) && (count <= SPB_MAX_BYTES);
	wire timer_zero = (timer == 16'h0000);
	wire strobe_on = (state == ST_STROBE);
	wire last_byte = (byte_idx == last_idx);
	wire [2:0] data_pos = SPB_DATA_POS + byte_idx;
	wire [15:0] width_cyc = 16'(STROBE_BASE_CYC + int'(act_len) * STROBE_STEP_CYC);
	wire [15:0] gap_cyc = 16'(int'(act_del) * GAP_STEP_CYC);

	// Reply buffer absorbs a stalled host without losing bytes
	logic buf_ready;
	wire rsp_push = (state == ST_REPLY);

	assign cmd_ready_o = (state == ST_IDLE);
	assign busy_o = (state != ST_IDLE);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_timer = timer;
		case (state)
			ST_IDLE: begin
				if (pkt_done && (is_out || is_in)) begin
					next_state = count_ok ? ST_SETUP : ST_REPLY;
					next_timer = SPB_SETUP_CYC;
				end
			end
			ST_SETUP: begin
				next_timer = timer - 16'h0001;
				if (timer_zero) begin
					next_state = ST_STROBE;
					next_timer = width_cyc;
				end
			end
			ST_STROBE: begin
				next_timer = timer - 16'h0001;
				if (timer_zero) begin
					next_state = ST_HOLD;
					next_timer = SPB_HOLD_CYC;
				end
			end
			ST_HOLD: begin
				next_timer = timer - 16'h0001;
				if (timer_zero) begin
					next_state = last_byte ? ST_REPLY : ST_GAP;
					next_timer = gap_cyc;
				end
			end
			ST_GAP: begin
				next_timer = timer - 16'h0001;
				if (timer_zero) begin
					next_state = ST_SETUP;
					next_timer = SPB_SETUP_CYC;
				end
			end
			ST_REPLY: begin
				if (buf_ready && (pkt_idx == SPB_LAST_POS)) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_timer = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ST_IDLE;
			timer <= 16'h0000;
			pkt_idx <= 3'h0;
			byte_idx <= 3'h0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			if (cmd_take || (rsp_push && buf_ready)) begin
				pkt_idx <= pkt_idx + 3'h1;
			end
			if (pkt_done) begin
				byte_idx <= 3'h0;
			end else if (state == ST_HOLD && timer_zero && !last_byte) begin
				byte_idx <= byte_idx + 3'h1;
			end
		end
	end

	// Settings are frozen per burst so a register write mid-burst cannot
	// move the strobe onto another line.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			act_write <= 1'b0;
			act_port <= 1'b0;
			act_line <= '0;
			act_pos <= 1'b0;
			act_len <= 8'h00;
			act_del <= 8'h00;
			last_idx <= 3'h0;
		end else if (state == ST_IDLE && pkt_done) begin
			act_write <= is_out;
			act_port <= cfg_port;
			act_line <= cfg_sel[SPB_LINE_W-1:0];
			act_pos <= cfg_sel[SPB_SEL_POL_BIT];
			act_len <= cfg_len;
			act_del <= cfg_del;
			last_idx <= count[2:0] - 3'h1;
		end
	end

	// ------------------------------------------------------------
	// Packet storage
	// ------------------------------------------------------------
	logic [SPB_LINES-1:0] pin_sync;
	wire [7:0] port_sample = act_port ? pin_sync[15:8] : pin_sync[7:0];
	wire sample_now = strobe_on && timer_zero && !act_write;

	genvar g;
	generate
		for (g = 0; g < SPB_PKT_LEN; g++) begin : g_pkt
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					cmd_mem[g] <= 8'h00;
					rsp_mem[g] <= 8'h00;
				end else begin
					if (cmd_take && pkt_idx == 3'(g)) begin
						cmd_mem[g] <= cmd_data_i;
					end
					if (state == ST_IDLE && pkt_done) begin
						// Opcode echoed, all other reply bytes cleared
						rsp_mem[g] <= (g == 0) ? opcode : 8'h00;
					end else if (sample_now && data_pos == 3'(g)) begin
						rsp_mem[g] <= port_sample;
					end
				end
			end
		end
	endgenerate

	spb_sync #(
		.WIDTH(SPB_LINES)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.async_i(pin_in_i),
		.sync_o(pin_sync)
	);

	spb_fifo #(
		.WIDTH(8),
		.DEPTH(2)
	) u_rsp_buf (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(rsp_push),
		.in_ready_o(buf_ready),
		.in_data_i(rsp_mem[pkt_idx]),
		.out_valid_o(rsp_valid_o),
		.out_ready_i(rsp_ready_i),
		.out_data_o(rsp_data_o)
	);

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	// Data stays on the port from setup through hold. Read bursts never
	// touch directions; the strobe line's direction is left to software.
	wire drive_data = act_write && (state == ST_SETUP || state == ST_STROBE || state == ST_HOLD);
	wire [7:0] out_byte = cmd_mem[data_pos];
	wire [SPB_LINES-1:0] data_mask = act_port ? 16'hff00 : 16'h00ff;
	wire [SPB_LINES-1:0] data_bits = act_port ? {out_byte, 8'h00} : {8'h00, out_byte};
	wire [SPB_LINES-1:0] line_mask = 16'h0001 << act_line;
	wire [SPB_LINES-1:0] with_data = drive_data ?
		((base_out_i & ~data_mask) | data_bits) : base_out_i;
	wire [SPB_LINES-1:0] next_pin_out = strobe_on ?
		((with_data & ~line_mask) | (act_pos ? line_mask : 16'h0000)) : with_data;
	wire [SPB_LINES-1:0] next_pin_oe_n = drive_data ?
		(base_oe_n_i & ~data_mask) : base_oe_n_i;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_out_o <= 16'h0000;
			pin_oe_n_o <= 16'hffff;
		end else begin
			pin_out_o <= next_pin_out;
			pin_oe_n_o <= next_pin_oe_n;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_wr_echo;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		rsp_push && buf_ready && pkt_idx == SPB_OPC_POS && act_write
			|-> rsp_mem[SPB_OPC_POS] == burst_pulsed_output_opcode;
	endproperty
	a_wr_echo: assert property (p_wr_echo) else $error("write reply opcode wrong");

	property p_rd_echo;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		rsp_push && buf_ready && pkt_idx == SPB_OPC_POS && !act_write
			|-> rsp_mem[SPB_OPC_POS] == burst_pulsed_input_opcode;
	endproperty
	a_rd_echo: assert property (p_rd_echo) else $error("read reply opcode wrong");

	property p_bad_count;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		state == ST_IDLE && pkt_done && (is_out || is_in) && !count_ok |=> state == ST_REPLY;
	endproperty
	a_bad_count: assert property (p_bad_count) else $error("bad count still strobed");

	property p_strobe_level;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		strobe_on |=> pin_out_o[act_line] == act_pos;
	endproperty
	a_strobe_level: assert property (p_strobe_level) else $error("strobe level wrong");

	property p_strobe_hold;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		strobe_on && !timer_zero |=> strobe_on && timer == $past(timer) - 16'h0001;
	endproperty
	a_strobe_hold: assert property (p_strobe_hold) else $error("strobe ended early");

	property p_data_stable;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		act_write && strobe_on |=> ##1 $stable(pin_out_o & data_mask & ~line_mask)
			&& (pin_oe_n_o & data_mask) == 16'h0000;
	endproperty
	a_data_stable: assert property (p_data_stable) else $error("data moved in strobe");

	property p_read_no_drive;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		busy_o && !act_write |=> pin_oe_n_o == $past(base_oe_n_i);
	endproperty
	a_read_no_drive: assert property (p_read_no_drive) else $error("read drove port");

	property p_byte_limit;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		busy_o |-> {5'h00, byte_idx} < SPB_MAX_BYTES;
	endproperty
	a_byte_limit: assert property (p_byte_limit) else $error("more than six bytes");

	property p_sample_slot;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		sample_now |=> rsp_mem[$past(data_pos)] == $past(port_sample);
	endproperty
	a_sample_slot: assert property (p_sample_slot) else $error("read byte misplaced");
endmodule : spb_burst

// *** dv/spb_periph_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Parallel peripheral on the strobed port
// ------------------------------------------------------------
module spb_periph_model (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [15:0] pin_out_i,
	input wire logic [15:0] pin_oe_n_i,
	input wire logic [3:0] line_i,
	input wire logic pol_i,
	input wire logic port_b_i,
	output logic [15:0] pin_in_o
);
	logic [7:0] wr_q[$];
	int n_strobes;
	int width;
	int gap;
	int last_gap;
	int viol;
	logic act_q;
	logic toggle;
	logic [7:0] dat_q;
	logic [15:0] ext;
	logic [15:0] lvl;
	logic act;
	logic [7:0] dat;

	function automatic logic [7:0] rd_val(input int s);
		return 8'h3c ^ 8'(s * 41);
	endfunction : rd_val

	// Released lines off the data port flip every cycle so a stale level is never mistaken for data
	always_comb begin
		ext = toggle ? 16'haaaa : 16'h5555;
		if (port_b_i) begin
			ext[15:8] = rd_val(n_strobes);
		end else begin
			ext[7:0] = rd_val(n_strobes);
		end
		lvl = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & ext);
		pin_in_o = lvl;
		// An undriven line is no strobe, so release from reset makes no false edge
		act = !pin_oe_n_i[line_i] && (lvl[line_i] == pol_i);
		dat = port_b_i ? lvl[15:8] : lvl[7:0];
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			act_q <= 1'b0;
			toggle <= 1'b0;
			n_strobes <= 0;
			width <= 0;
			gap <= 0;
			last_gap <= 0;
			viol <= 0;
			dat_q <= 8'h00;
		end else begin
			toggle <= ~toggle;
			act_q <= act;
			dat_q <= dat;
			if (act && !act_q) begin
				wr_q.push_back(dat);
				width <= 1;
				last_gap <= gap;
			end else if (act) begin
				width <= width + 1;
				if (dat !== dat_q) begin
					viol <= viol + 1;
				end
			end
			if (!act && act_q) begin
				n_strobes <= n_strobes + 1;
				gap <= 1;
			end else if (!act) begin
				gap <= gap + 1;
			end
		end
	end
endmodule : spb_periph_model

// *** dv/tb_spb_burst.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_spb_burst
	import spb_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic cmd_valid_i = 1'b0;
	logic cmd_ready_o;
	logic [7:0] cmd_data_i = 8'h00;
	logic rsp_valid_o;
	logic rsp_ready_i = 1'b0;
	logic [7:0] rsp_data_o;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic [15:0] pin_in_i;
	logic [15:0] pin_out_o;
	logic [15:0] pin_oe_n_o;
	logic busy_o;
	logic [3:0] m_line = 4'hf;
	logic m_pol = 1'b0;
	logic m_portb = 1'b0;
	int n_errors = 0;
	int comparisons = 0;

	// Strobe lines A.0, B.0, B.7 are outputs at their idle levels before any burst
	spb_burst #(.STROBE_BASE_CYC(4), .STROBE_STEP_CYC(1), .GAP_STEP_CYC(1)) dut_u (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_data_i(cmd_data_i),
		.rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i), .rsp_data_o(rsp_data_o),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.base_out_i(16'h8000), .base_oe_n_i(16'h7efe),
		.pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o), .busy_o(busy_o)
	);

	spb_periph_model model_u (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .pin_out_i(pin_out_o),
		.pin_oe_n_i(pin_oe_n_o), .line_i(m_line), .pol_i(m_pol), .port_b_i(m_portb),
		.pin_in_o(pin_in_i)
	);

	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : reg_wr

	task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1;
		`CHK(reg_rdata_o, e)
	endtask : reg_chk

	task automatic cfg(input logic [4:0] sel, input logic pb, input logic [7:0] len, dl);
		reg_wr(SPB_ADDR_SEL, {23'h0, pb, 3'h0, sel});
		reg_wr(SPB_ADDR_LEN, {24'h0, len});
		reg_wr(SPB_ADDR_DEL, {24'h0, dl});
		m_line <= sel[3:0];
		m_pol <= sel[4];
		m_portb <= pb;
	endtask : cfg

	task automatic send_pkt(input logic [7:0] op, cnt, d0);
		@(posedge clk_sys_i);
		for (int i = 0; i < 8; i++) begin
			cmd_valid_i <= 1'b1;
			cmd_data_i <= (i == 0) ? op : (i == 1) ? cnt : d0 + 8'(i);
			do @(posedge clk_sys_i); while (cmd_ready_o !== 1'b1);
		end
		cmd_valid_i <= 1'b0;
	endtask : send_pkt

	task automatic burst(input logic [7:0] op, cnt, d0, input bit chk_busy);
		int s0;
		int q0;
		bit ok;
		logic [7:0] e;
		s0 = model_u.n_strobes;
		q0 = model_u.wr_q.size();
		ok = (cnt >= 8'h01) && (cnt <= 8'h06);
		send_pkt(op, cnt, d0);
		if (chk_busy) begin
			reg_chk(SPB_ADDR_STATUS, 32'h0000_0001);
		end
		for (int i = 0; i < 8; i++) begin
			if (i == 4) begin
				rsp_ready_i <= 1'b0;
				repeat (3) @(posedge clk_sys_i);
			end
			rsp_ready_i <= 1'b1;
			do @(posedge clk_sys_i); while (rsp_valid_o !== 1'b1);
			// A.0 is a host-driven strobe output, so it reads back low
			e = (i == 0) ? op : ok ? (model_u.rd_val(s0 + i - 2) & 8'hfe) : 8'h00;
			if (i == 0 || !ok || (op == burst_pulsed_input_opcode && i >= 2 && i < 2 + cnt)) begin
				`CHK(rsp_data_o, e)
			end
		end
		rsp_ready_i <= 1'b0;
		`CHK(8'(model_u.n_strobes - s0), ok ? cnt : 8'h00)
		if (op == burst_pulsed_output_opcode && ok) begin
			for (int j = 0; j < cnt; j++) begin
				`CHK(model_u.wr_q[q0 + j], d0 + 8'(j + 2))
			end
		end
	endtask : burst

	task automatic end_sim;
		if (n_errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		n_errors++;
		end_sim();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		reg_chk(SPB_ADDR_SEL, 32'h0000_000f);
		reg_chk(SPB_ADDR_LEN, 32'h0000_0000);
		reg_chk(SPB_ADDR_DEL, 32'h0000_0000);
		reg_wr(SPB_ADDR_SEL, 32'hffff_ffff);
		reg_chk(SPB_ADDR_SEL, 32'h0000_011f);
		reg_wr(8'h10, 32'hffff_ffff);
		reg_chk(8'h10, 32'h0000_0000);
		cfg(5'h0f, 1'b0, 8'h00, 8'h00);
		burst(burst_pulsed_output_opcode, 8'h06, 8'h10, 1'b0);
		cfg(5'h10, 1'b1, 8'h00, 8'h00);
		burst(burst_pulsed_output_opcode, 8'h01, 8'ha9, 1'b0);
		cfg(5'h0f, 1'b0, 8'h00, 8'h00);
		burst(burst_pulsed_input_opcode, 8'h06, 8'hf0, 1'b0);
		cfg(5'h18, 1'b0, 8'h00, 8'h00);
		burst(burst_pulsed_input_opcode, 8'h03, 8'h37, 1'b0);
		cfg(5'h0f, 1'b0, 8'h02, 8'h03);
		burst(burst_pulsed_output_opcode, 8'h02, 8'h60, 1'b1);
		`CHK(model_u.width, 7)
		// Idle line between strobes: hold 2, delay 3 plus 1, setup 3 cycles
		`CHK(model_u.last_gap, 9)
		`CHK(model_u.viol, 0)
		burst(burst_pulsed_output_opcode, 8'h00, 8'h00, 1'b0);
		burst(burst_pulsed_output_opcode, 8'h07, 8'h00, 1'b0);
		burst(burst_pulsed_input_opcode, 8'h00, 8'h00, 1'b0);
		burst(burst_pulsed_input_opcode, 8'h07, 8'h00, 1'b0);
		send_pkt(8'h0c, 8'h01, 8'h00);
		repeat (60) @(posedge clk_sys_i);
		`CHK(rsp_valid_o, 1'b0)
		`CHK(busy_o, 1'b0)
		`CHK(cmd_ready_o, 1'b1)
		end_sim();
	end
endmodule : tb_spb_burst
